/* File: bench/stx_sva.sv */
// assertions for the swap, skip, table-read and xor block
`timescale 1ns/1ps
module stx_sva (
	input wire clk,
	input wire sys_rst,
	input wire ce,
	input wire issue,
	input wire busy,
	input wire [3:0] op,
	input wire [7:0] mem_rdata,
	input wire [2:0] bit_sel,
	input wire [7:0] acc,
	input wire [5:0] status,
	input wire rom_rd,
	input wire mem_we,
	input wire [7:0] mem_wdata,
	input wire discard_fetch,
	input wire done
);
default clocking cb @(posedge clk); endclocking
default disable iff (sys_rst);
// a request only counts when the block is idle and enabled
wire t = ce && issue && !busy;
wire z = mem_rdata == 8'h00;
property p_swap;
	t && op == 4'h1 |=> {acc[3:0], acc[7:4]} == $past(mem_rdata);
endproperty
a_swap: assert property (p_swap) else $error("swap");
property p_skz; t && op[3:1] == 3'h1 && z |=> discard_fetch && busy ##1 done;
endproperty
a_skz: assert property (p_skz) else $error("skip");
property p_sknz; t && op == 4'h2 && !z |=> done && !discard_fetch;
endproperty
a_sknz: assert property (p_sknz) else $error("no skip");
property p_sza; t && op == 4'h3 |=> acc == $past(mem_rdata);
endproperty
a_sza: assert property (p_sza) else $error("move");
property p_bit; t && op == 4'h4 && !mem_rdata[bit_sel] |=> discard_fetch;
endproperty
a_bit: assert property (p_bit) else $error("bit skip");
property p_trd; t && (op == 4'h5 || op == 4'h6) |=> rom_rd ##1 mem_we && done;
endproperty
a_trd: assert property (p_trd) else $error("table");
property p_xor_to_memory;
	t && op == 4'h8 |=> mem_we && mem_wdata == ($past(acc) ^ $past(mem_rdata));
endproperty
a_xor_to_memory: assert property (p_xor_to_memory) else $error("xor_to_memory");
property p_flag; t && op > 4'h0 && op < 4'h7 |=> $stable(status);
endproperty
a_flag: assert property (p_flag) else $error("flags");
property p_xorz;
	t && (op == 4'h7 || op == 4'h9) |=> status[2] == (acc == 8'h00);
endproperty
a_xorz: assert property (p_xorz) else $error("xor zero");
property p_hold; !ce |=> $stable(acc) && $stable(status) && $stable(done);
endproperty
a_hold: assert property (p_hold) else $error("frozen");
endmodule
bind stx_exec stx_sva u_sva (
	.clk(clk),
	.sys_rst(sys_rst),
	.ce(ce),
	.issue(issue),
	.busy(busy),
	.op(op),
	.mem_rdata(mem_rdata),
	.bit_sel(bit_sel),
	.acc(acc),
	.status(status),
	.rom_rd(rom_rd),
	.mem_we(mem_we),
	.mem_wdata(mem_wdata),
	.discard_fetch(discard_fetch),
	.done(done)
);

/* File: bench/testbench.sv */
// randomised bench for the execution block
`timescale 1ns/1ps
module testbench;
logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, issue = 1'b0;
logic [3:0] op = 4'h0, pc_page = 4'h0;
logic [7:0] mem_rdata = 8'h00, imm = 8'h00, mem_addr = 8'h00;
logic [7:0] tbl_ptr = 8'h00, ea = 8'h00, eh = 8'h00, wx;
logic [2:0] bit_sel = 3'h0;
logic [15:0] rom_rdata = 16'h0000, r = 16'h0034;
logic [11:0] rom_addr;
logic [7:0] mem_wdata, mem_waddr, acc, table_high_latch;
logic [5:0] status;
logic rom_rd, mem_we, discard_fetch, busy, done, ez = 1'b0, sk, tr;
integer mismatches = 0, compares = 0, cyc = 0, i, n;
stx_exec u_stx_exec (
	.clk(clk),
	.sys_rst(sys_rst),
	.ce(ce),
	.issue(issue),
	.op(op),
	.mem_rdata(mem_rdata),
	.imm(imm),
	.bit_sel(bit_sel),
	.mem_addr(mem_addr),
	.pc_page(pc_page),
	.tbl_ptr(tbl_ptr),
	.rom_rdata(rom_rdata),
	.rom_addr(rom_addr),
	.rom_rd(rom_rd),
	.mem_we(mem_we),
	.mem_wdata(mem_wdata),
	.mem_waddr(mem_waddr),
	.acc(acc),
	.table_high_latch(table_high_latch),
	.status(status),
	.discard_fetch(discard_fetch),
	.busy(busy),
	.done(done)
);
initial forever #10 clk = ~clk;
function [15:0] lf(input [15:0] v);
	lf = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
endfunction
task chk(input [15:0] seen, input [15:0] exp, input string nm);
	compares = compares + 1;
	if (seen !== exp) begin
		mismatches = mismatches + 1;
		$display("Error %s exp %h seen %h", nm, exp, seen);
	end
endtask
task finish_test;
	$display("compares %0d mismatches %0d", compares, mismatches);
	if (mismatches == 0 && compares > 0) $display("*** PASS ***");
	else $display("*** FAIL ***");
	$finish;
endtask
always @(posedge clk) if (++cyc > 3000) begin
	mismatches = mismatches + 1;
	finish_test;
end
// ****
// main sequence
// ****
initial begin
	repeat (6) @(negedge clk);
	sys_rst = 1'b0;
	for (i = 0; i < 300; i = i + 1) begin
		r = lf(r);
		// first ten: every opcode on a zero byte; then zero bytes stay common
		op = i < 10 ? i[3:0] : r[3:0] % 4'ha;
		mem_rdata = (i < 10 || r[6:4] == 3'h0) ? 8'h00 : r[15:8];
		r = lf(lf(r));
		{imm, tbl_ptr} = r;
		{pc_page, mem_addr, bit_sel} = r[14:0];
		// the program word is held through the whole read
		rom_rdata = lf(r);
		// an issue while ce is low must leave every state alone
		if (r[7]) begin
			ce = 1'b0;
			issue = 1'b1;
			@(negedge clk);
			chk(acc, ea, "frozen acc");
			chk(status, {3'h0, ez, 2'h0}, "frozen status");
			chk(busy, 1'b0, "frozen busy");
			ce = 1'b1;
		end
		wx = ea ^ (op == 4'h9 ? imm : mem_rdata);
		sk = op == 4'h4 ? !mem_rdata[bit_sel] :
			(op == 4'h2 || op == 4'h3) && mem_rdata == 8'h00;
		tr = op == 4'h5 || op == 4'h6;
		if (op == 4'h1) ea = {mem_rdata[3:0], mem_rdata[7:4]};
		if (op == 4'h3) ea = mem_rdata;
		if (op == 4'h7 || op == 4'h9) ea = wx;
		if (op > 4'h6) ez = wx == 8'h00;
		if (tr) eh = rom_rdata[15:8];
		issue = 1'b1;
		@(negedge clk);
		issue = 1'b0;
		chk(discard_fetch, sk, "discard");
		if (tr) chk(rom_addr, {op == 4'h6 ? 4'hf : pc_page, tbl_ptr},
			"raddr");
		chk(rom_rd, tr, "rd");
		chk(busy, sk || tr, "busy");
		for (n = 1; done !== 1'b1 && n < 4; n = n + 1) @(negedge clk);
		chk(n, sk || tr ? 16'h0002 : 16'h0001, "cycles");
		chk(acc, ea, "acc");
		chk(table_high_latch, eh, "latch");
		chk(status, {3'h0, ez, 2'h0}, "status");
		chk(mem_we, tr || op == 4'h8, "we");
		if (tr || op == 4'h8) chk({mem_waddr, mem_wdata},
			{mem_addr, tr ? rom_rdata[7:0] : wx}, "wdata");
	end
	finish_test;
end
endmodule

/* File: rtl/stx_alu.v */
// combinational datapath for swap and exclusive-or results
`timescale 1ns/1ps
module stx_alu (
	op,
	acc,
	mem,
	imm,
	result,
	zero
);
`include "stx_consts.vh"
input wire [3:0] op;
input wire [7:0] acc;
input wire [7:0] mem;
input wire [7:0] imm;
output reg [7:0] result;
output wire zero;
always @* begin
	case (op)
		`STX_OP_SWAP_ACC: result = {mem[3:0], mem[7:4]}; // [RULE_01]
		`STX_OP_XOR: result = acc ^ mem; // [RULE_07]
		`STX_OP_XOR_MEM: result = mem ^ acc; // [RULE_08]
		`STX_OP_XORI: result = acc ^ imm; // [RULE_09]
		default: result = mem;
	endcase
end
assign zero = (result == 8'h00);
endmodule

/* File: rtl/stx_consts.vh */
// constants for the skip, table-read and exclusive-or execution block
// Operation
// RULE_01: nibble swap puts crossed operand nibbles in accumulator
// RULE_02: skip_if_zero on zero byte drops prefetch, adds dummy cycle
// RULE_03: move_skip_if_zero copies byte to accumulator, skips if zero
// RULE_04: bit-test skip takes two cycles when the selected bit is zero
// RULE_05: current-page table read: low byte to memory, high to latch
// RULE_06: last-page table read uses final page at table_pointer offset
// RULE_07: xor with memory writes accumulator xor byte into accumulator
// RULE_08: xor_to_memory stores accumulator xor byte in memory, sets zero
// RULE_09: immediate xor puts accumulator xor immediate byte in accumulator
// RULE_10: xor variants change only zero flag; other five flags untouched
// RULE_11: swap, skip and table reads leave every status flag unchanged
`ifndef STX_CONSTS_VH
`define STX_CONSTS_VH
// ****************************************
// operation codes
// ****************************************
`define STX_OP_NOP 4'h0
`define STX_OP_SWAP_ACC 4'h1
`define STX_OP_SKZ 4'h2
`define STX_OP_MOVE_SKZ 4'h3
`define STX_OP_SKBIT 4'h4
`define STX_OP_TRDC 4'h5
`define STX_OP_TRDL 4'h6
`define STX_OP_XOR 4'h7
`define STX_OP_XOR_MEM 4'h8
`define STX_OP_XORI 4'h9
// ****************************************
// reset values and status flag positions
// ****************************************
`define STX_ACC_RST 8'h00
`define STX_TABLE_HIGH_LATCH_RST 8'h00
`define STX_STAT_RST 6'h00
`define STX_FLAG_Z 2
`endif

/* File: rtl/stx_exec.v */
// execution block for swap, skip, table-read and exclusive-or instructions
`timescale 1ns/1ps
module stx_exec #(
	parameter PC_W = 12,
	parameter PAGE_W = 8
) (
	clk,
	sys_rst,
	ce,
	issue,
	op,
	mem_rdata,
	imm,
	bit_sel,
	mem_addr,
	pc_page,
	tbl_ptr,
	rom_rdata,
	rom_addr,
	rom_rd,
	mem_we,
	mem_wdata,
	mem_waddr,
	acc,
	table_high_latch,
	status,
	discard_fetch,
	busy,
	done
);
`include "stx_consts.vh"
input wire clk;
input wire sys_rst;
input wire ce;
input wire issue;
input wire [3:0] op;
input wire [7:0] mem_rdata;
input wire [7:0] imm;
input wire [2:0] bit_sel;
input wire [7:0] mem_addr;
input wire [PC_W-PAGE_W-1:0] pc_page;
input wire [PAGE_W-1:0] tbl_ptr;
input wire [15:0] rom_rdata;
output reg [PC_W-1:0] rom_addr;
output reg rom_rd;
output reg mem_we;
output reg [7:0] mem_wdata;
output reg [7:0] mem_waddr;
output reg [7:0] acc;
output reg [7:0] table_high_latch;
output reg [5:0] status;
output reg discard_fetch;
output reg busy;
output reg done;

// ****************************************
// state machine
// ****************************************
localparam ST_IDLE = 2'b00;
localparam ST_DUMMY = 2'b01;
localparam ST_TABLE = 2'b10;
localparam [PC_W-PAGE_W-1:0] LAST_PAGE = {(PC_W-PAGE_W){1'b1}};

reg [1:0] state;
reg [7:0] tbl_dest;
wire [7:0] alu_result;
wire alu_zero;
wire skip_now;

stx_alu u_alu (
	.op(op),
	.acc(acc),
	.mem(mem_rdata),
	.imm(imm),
	.result(alu_result),
	.zero(alu_zero)
);

// ****************************************
// skip decision and table address
// ****************************************
// one decoder for all skip forms keeps their conditions in step
function skip_cond;
	input [3:0] code;
	input [7:0] byte_val;
	input [2:0] sel;
	begin
		if (code == `STX_OP_SKBIT) begin
			skip_cond = ~byte_val[sel]; // [RULE_04]
		end else if (code == `STX_OP_SKZ) begin
			skip_cond = (byte_val == 8'h00); // [RULE_02]
		end else if (code == `STX_OP_MOVE_SKZ) begin
			skip_cond = (byte_val == 8'h00); // [RULE_03]
		end else begin
			skip_cond = 1'b0;
		end
	end
endfunction

// both table reads differ only in the page they use
function [PC_W-1:0] table_addr;
	input [PC_W-PAGE_W-1:0] page;
	input [PAGE_W-1:0] ptr;
	begin
		table_addr = {page, ptr};
	end
endfunction

assign skip_now = skip_cond(op, mem_rdata, bit_sel);

// ****************************************
// execution
// ****************************************
// status only ever changes on the zero bit of an xor; all others hold
always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		state <= ST_IDLE;
		acc <= `STX_ACC_RST;
		table_high_latch <= `STX_TABLE_HIGH_LATCH_RST;
		status <= `STX_STAT_RST;
		rom_addr <= {PC_W{1'b0}};
		rom_rd <= 1'b0;
		mem_we <= 1'b0;
		mem_wdata <= 8'h00;
		mem_waddr <= 8'h00;
		tbl_dest <= 8'h00;
		discard_fetch <= 1'b0;
		busy <= 1'b0;
		done <= 1'b0;
	end else if (ce) begin
		mem_we <= 1'b0;
		rom_rd <= 1'b0;
		discard_fetch <= 1'b0;
		done <= 1'b0;
		case (state)
			ST_IDLE: begin
				if (issue) begin
					case (op)
						`STX_OP_SWAP_ACC: begin
							acc <= alu_result; // [RULE_01] [RULE_11]
							done <= 1'b1;
						end
						`STX_OP_SKZ: begin
							if (skip_now) begin
								discard_fetch <= 1'b1; // [RULE_02]
								busy <= 1'b1;
								state <= ST_DUMMY;
							end else begin
								done <= 1'b1; // [RULE_02]
							end
						end
						`STX_OP_MOVE_SKZ: begin
							acc <= mem_rdata; // [RULE_03] [RULE_11]
							if (skip_now) begin
								discard_fetch <= 1'b1; // [RULE_03]
								busy <= 1'b1;
								state <= ST_DUMMY;
							end else begin
								done <= 1'b1;
							end
						end
						`STX_OP_SKBIT: begin
							if (skip_now) begin
								discard_fetch <= 1'b1; // [RULE_04]
								busy <= 1'b1;
								state <= ST_DUMMY;
							end else begin
								done <= 1'b1; // [RULE_04]
							end
						end
						`STX_OP_TRDC: begin
							rom_addr <= table_addr(pc_page, tbl_ptr); // [RULE_05]
							rom_rd <= 1'b1;
							tbl_dest <= mem_addr;
							busy <= 1'b1;
							state <= ST_TABLE;
						end
						`STX_OP_TRDL: begin
							rom_addr <= table_addr(LAST_PAGE, tbl_ptr); // [RULE_06]
							rom_rd <= 1'b1;
							tbl_dest <= mem_addr;
							busy <= 1'b1;
							state <= ST_TABLE;
						end
						`STX_OP_XOR, `STX_OP_XORI: begin
							acc <= alu_result; // [RULE_07] [RULE_09]
							status[`STX_FLAG_Z] <= alu_zero; // [RULE_10]
							done <= 1'b1;
						end
						`STX_OP_XOR_MEM: begin
							mem_we <= 1'b1; // [RULE_08]
							mem_waddr <= mem_addr;
							mem_wdata <= alu_result;
							status[`STX_FLAG_Z] <= alu_zero; // [RULE_08] [RULE_10]
							done <= 1'b1;
						end
						default: begin
							done <= 1'b1;
						end
					endcase
				end
			end
			ST_DUMMY: begin
				// dummy cycle replaces the discarded prefetch
				busy <= 1'b0;
				done <= 1'b1;
				state <= ST_IDLE;
			end
			ST_TABLE: begin
				// rom word is valid one cycle after the read strobe
				mem_we <= 1'b1; // [RULE_05] [RULE_06]
				mem_waddr <= tbl_dest;
				mem_wdata <= rom_rdata[7:0];
				table_high_latch <= rom_rdata[15:8]; // [RULE_05] [RULE_06]
				busy <= 1'b0;
				done <= 1'b1;
				state <= ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
			end
		endcase
	end
end
endmodule
